/* src/iop_bus.sv */
// iop_bus.sv: external bus cycle engine for program, data and i/o spaces
// assumes the core holds req stable from req_valid until req_ready;
// ready pin comes from external decode logic, asynchronous to sys_clk
//
// Overview of operation
// - io_space_select_n goes low from the first cycle of every i/o cycle.
// - i/o cycles use identical strobe, direction and wait timing as memory.
// - sixteen input and sixteen output ports reachable by in/out requests.
// - port number sits on the four low address lines during i/o cycles.
// - in requests make i/o read cycles; out requests make i/o write cycles.
// - slow peripherals hold ready low; the cycle waits until ready rises.
`timescale 1ns/1ps
`include "iop_defines.svh"
module iop_bus
(
  // clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // core side
  input  wire logic                   req_valid,
  input  wire iop_pkg::iop_req_t      req,
  output logic                        req_ready,
  output logic [`IOP_DATA_W-1:0]      rdata,
  // i/o instruction side: port index only
  input  wire logic                   port_valid,
  input  wire logic                   port_write,
  input  wire logic [`IOP_PORT_W-1:0] port_num,
  input  wire logic [`IOP_DATA_W-1:0] port_wdata,
  output logic                        port_ready,
  // external bus
  output logic [`IOP_ADDR_W-1:0]      addr,
  output logic [`IOP_DATA_W-1:0]      data_out,
  output logic                        data_oe,
  input  wire logic [`IOP_DATA_W-1:0] data_in,
  output iop_pkg::iop_ctl_t           ctl,
  input  wire logic                   ready
);
  import iop_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    IOP_IDLE   = 3'h1,
    IOP_SETUP  = 3'h2,
    IOP_STROBE = 3'h4
  } iop_state_t;

  iop_state_t state;
  iop_req_t   cur;
  logic       cur_port;
  logic [2:0] rdy_sync;
  logic       rdy;
  iop_req_t   next_req;
  logic       take;

  // ------------------------------------------------------------
  // ready pin synchroniser
  // ------------------------------------------------------------
  // held until the last two stages agree so a glitch cannot end a cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdy_sync <= 3'h0;
      rdy      <= 1'b0;
    end
    else if (clk_en)
    begin
      // restart at every cycle end so a ready left over from the last
      // peripheral cannot end the next cycle early; a one-cycle leftover
      // is rejected by the agreement test
      if (state == IOP_STROBE && rdy)
      begin
        rdy_sync <= 3'h0;
        rdy      <= 1'b0;
      end
      else
      begin
        rdy_sync <= {rdy_sync[1:0], ready};
        if (rdy_sync[2] == rdy_sync[1])
          rdy <= rdy_sync[1];
      end
    end
  end

  // ------------------------------------------------------------
  // request selection
  // ------------------------------------------------------------
  always_comb
  begin
    next_req = req;
    if (port_valid)
    begin
      next_req.space = IOP_SPACE_IO;
      next_req.write = port_write;
      next_req.addr  = {`IOP_ADDR_HI_RST, port_num};
      next_req.wdata = port_wdata;
    end
  end

  // port requests win; memory request waits until the port cycle ends
  assign take       = clk_en && (state == IOP_IDLE) && (port_valid || req_valid);
  assign req_ready  = clk_en && (state == IOP_STROBE) && rdy && !cur_port;
  assign port_ready = clk_en && (state == IOP_STROBE) && rdy && cur_port;

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  // one shared sequence for every space keeps i/o timing identical
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state    <= IOP_IDLE;
      cur      <= '0;
      cur_port <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state)
        IOP_IDLE:
        begin
          if (take)
          begin
            cur      <= next_req;
            cur_port <= port_valid;
            state    <= IOP_SETUP;
          end
        end
        IOP_SETUP:
          state <= IOP_STROBE;
        IOP_STROBE:
        begin
          if (rdy)
            state <= IOP_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // bus pins
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addr     <= '0;
      data_out <= `IOP_DATA_RST;
      data_oe  <= 1'b0;
      ctl      <= `IOP_CTL_IDLE;
      rdata    <= `IOP_DATA_RST;
    end
    else if (clk_en)
    begin
      if (take)
      begin
        addr     <= next_req.addr;
        data_out <= next_req.wdata;
        data_oe  <= next_req.write;
        ctl.rd_wr <= !next_req.write;
        ctl.program_space_select_n <= (next_req.space != IOP_SPACE_PROG);
        ctl.data_space_select_n    <= (next_req.space != IOP_SPACE_DATA);
        ctl.io_space_select_n      <= (next_req.space != IOP_SPACE_IO);
      end
      else if (state == IOP_SETUP)
        ctl.bus_strobe_n <= 1'b0;
      else if (state == IOP_STROBE && rdy)
      begin
        ctl <= `IOP_CTL_IDLE;
        data_oe <= 1'b0;
        if (!cur.write)
          rdata <= data_in;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_io_select_first: assert property (@(posedge sys_clk) disable iff (rst)
    (take && port_valid) |=> !ctl.io_space_select_n && ctl.bus_strobe_n)
    else $error("i/o select not low at cycle start");
  a_port_on_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (take && port_valid) |=> addr[`IOP_PORT_W-1:0] == $past(port_num))
    else $error("port number missing on low address");
  a_dir_matches: assert property (@(posedge sys_clk) disable iff (rst)
    (take && port_valid) |=> ctl.rd_wr == !$past(port_write) && data_oe == $past(port_write))
    else $error("in/out direction wrong");
  a_strobe_timing: assert property (@(posedge sys_clk) disable iff (rst)
    (take && clk_en) ##1 clk_en |=> !ctl.bus_strobe_n)
    else $error("strobe not low one cycle after setup");
  a_wait_ready: assert property (@(posedge sys_clk) disable iff (rst)
    (state == IOP_STROBE && !rdy) |=> state == IOP_STROBE && !ctl.bus_strobe_n)
    else $error("cycle ended without ready");
  a_one_space: assert property (@(posedge sys_clk) disable iff (rst)
    !ctl.io_space_select_n |-> ctl.program_space_select_n && ctl.data_space_select_n)
    else $error("two spaces selected");
  a_port_addr_hi: assert property (@(posedge sys_clk) disable iff (rst)
    (take && port_valid) |=> addr[`IOP_ADDR_W-1:`IOP_PORT_W] == `IOP_ADDR_HI_RST)
    else $error("upper address bits not zero in port cycle");
  a_wait_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (state == IOP_STROBE && !rdy) |=> $stable(addr) && $stable(ctl) && $stable(data_out))
    else $error("bus changed during wait state");
  a_strobe_in_space: assert property (@(posedge sys_clk) disable iff (rst)
    !ctl.bus_strobe_n |-> !(&{ctl.program_space_select_n, ctl.data_space_select_n,
                              ctl.io_space_select_n}))
    else $error("strobe low with no space selected");
  a_end_release: assert property (@(posedge sys_clk) disable iff (rst)
    (state == IOP_STROBE && rdy && clk_en) |=> ctl.bus_strobe_n && ctl.io_space_select_n
      && !data_oe)
    else $error("bus not released after cycle end");
  a_fresh_ready: assert property (@(posedge sys_clk) disable iff (rst)
    (state == IOP_STROBE && rdy && clk_en) |=> !rdy)
    else $error("ready kept across cycles");
  a_one_done: assert property (@(posedge sys_clk) disable iff (rst)
    !(req_ready && port_ready))
    else $error("both ready outputs high");
endmodule

/* src/iop_defines.svh */
// iop_defines.svh: constants of the i/o port bus cycle engine
// assumes inclusion by the package and the design file only
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH
`define IOP_ADDR_W        16
`define IOP_DATA_W        16
`define IOP_PORT_W        4
`define IOP_PORT_COUNT    16
`define IOP_ADDR_HI_RST   12'h000
`define IOP_DATA_RST      16'h0000
`define IOP_CTL_IDLE      5'h1F
`endif

/* src/iop_pkg.sv */
// iop_pkg.sv: types of the i/o port bus cycle engine
// assumes iop_defines.svh is on the include path
`include "iop_defines.svh"
package iop_pkg;
  typedef enum logic [1:0]
  {
    IOP_SPACE_PROG = 2'h0,
    IOP_SPACE_DATA = 2'h1,
    IOP_SPACE_IO   = 2'h2
  } iop_space_t;

  // one request from the core: which space, direction, address, data
  typedef struct packed
  {
    iop_space_t                space;
    logic                      write;
    logic [`IOP_ADDR_W-1:0]    addr;
    logic [`IOP_DATA_W-1:0]    wdata;
  } iop_req_t;

  // external bus control pins, all active low except rd_wr (high = read)
  typedef struct packed
  {
    logic program_space_select_n;
    logic data_space_select_n;
    logic io_space_select_n;
    logic bus_strobe_n;
    logic rd_wr;
  } iop_ctl_t;
endpackage

/* sim/iop_periph.sv */
// iop_periph.sv: far-side decode, output latches, input ports, ready
// assumes bus pins come from iop_bus on the same sys_clk
`timescale 1ns/1ps
module iop_periph
  import iop_pkg::*;
#(
  parameter logic [15:0] KEY = 16'h5A3C
)
(
  // clock
  input  wire logic        sys_clk,
  // bus from the device
  input  wire logic [15:0] addr,
  input  wire logic [15:0] data_out,
  input  wire iop_ctl_t    ctl,
  output logic [15:0]      data_in,
  output logic             ready,
  // strobe cycles before ready rises
  input  wire logic [3:0]  waits
);
  logic [15:0] latch [16];
  logic [15:0] last;
  logic [3:0]  cnt;
  logic        sel_rd;
  assign sel_rd = ctl.rd_wr && !(&{ctl.program_space_select_n, ctl.data_space_select_n,
                  ctl.io_space_select_n});
  // released bus shows the inverse, never a held copy
  assign data_in = sel_rd ? (KEY ^ addr) : ~last;
  assign ready = (cnt >= waits);
  always_ff @(posedge sys_clk)
  begin
    last <= data_in;
    cnt <= ctl.bus_strobe_n ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
    if (!ctl.io_space_select_n && !ctl.bus_strobe_n && !ctl.rd_wr)
      latch[addr[3:0]] <= data_out;
  end
endmodule

/* sim/tb_io_port_space_access.sv */
// tb_io_port_space_access.sv: bench of iop_bus against iop_periph
// assumes iop_pkg and iop_periph are compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_io_port_space_access;
  import iop_pkg::*;
  typedef struct packed {logic w; iop_space_t sp; logic [15:0] a; logic [15:0] e;} iop_note_t;
  logic        sys_clk = 0, rst = 1, req_valid = 0, port_valid = 0, port_write = 0;
  logic        req_ready, port_ready, data_oe, ready, clk_en = 1;
  logic [15:0] rdata, addr, data_out, data_in, port_wdata = 16'h0000;
  logic [3:0]  port_num = 4'h0, waits = 4'h0;
  iop_req_t    req = '0;
  iop_ctl_t    ctl;
  iop_note_t   q[$], nt;
  int          n_errors = 0, num_checks = 0, cyc = 0, seed = 32'h9bf8091d, nf, ns;
  iop_bus i_iop_bus (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rdata(rdata), .port_valid(port_valid),
    .port_write(port_write), .port_num(port_num), .port_wdata(port_wdata),
    .port_ready(port_ready), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .ctl(ctl), .ready(ready));
  iop_periph i_iop_periph (.sys_clk(sys_clk), .addr(addr), .data_out(data_out), .ctl(ctl),
    .data_in(data_in), .ready(ready), .waits(waits));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one bus cycle, held until its ready pulse; n is cycles to completion
  task automatic op(input logic p, w, input iop_space_t sp, input logic [15:0] a, d,
                    output int n);
    n = 0;
    @(posedge sys_clk);
    q.push_back('{w, sp, a, w ? d : (16'h5A3C ^ a)});
    if (p)
    begin
      port_valid <= 1; port_write <= w; port_num <= a[3:0]; port_wdata <= d;
    end
    else
    begin
      req_valid <= 1; req <= '{sp, w, a, d};
    end
    do @(posedge sys_clk); while (!(port_ready === 1 || req_ready === 1) && ++n < 99);
    port_valid <= 0;
    req_valid <= 0;
    `CHK("done", 1'b1, n < 99)
  endtask
  always
  begin
    @(posedge sys_clk);
    if (port_ready === 1 || req_ready === 1)
    begin
      nt = q.pop_front();
      `CHK("addr", nt.a, addr)
      `CHK("is_n", nt.sp != IOP_SPACE_IO, ctl.io_space_select_n)
      `CHK("ps_n", nt.sp != IOP_SPACE_PROG, ctl.program_space_select_n)
      `CHK("bus_strobe_n", 1'b0, ctl.bus_strobe_n)
      `CHK("rd_wr", ~nt.w, ctl.rd_wr)
      `CHK("p_rdy", nt.sp == IOP_SPACE_IO, port_ready)
      `CHK("ds_n", nt.sp != IOP_SPACE_DATA, ctl.data_space_select_n)
      `CHK("oe", nt.w, data_oe)
      `CHK("r_rdy", nt.sp != IOP_SPACE_IO, req_ready)
      `CHK("ready", 1'b1, ready)
      #1;
      `CHK("idle", 1'b1, ctl.bus_strobe_n)
      if (!nt.w) `CHK("rdata", nt.e, rdata)
      else if (nt.sp == IOP_SPACE_IO) `CHK("latch", nt.e, i_iop_periph.latch[nt.a[3:0]])
    end
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    for (int i = 0; i < 16; i++)
    begin
      op(1, 1, IOP_SPACE_IO, 16'(i), 16'($random(seed)), nf);
      op(1, 0, IOP_SPACE_IO, 16'(i), 16'h0000, nf);
    end
    op(0, 1, IOP_SPACE_DATA, 16'h8001, 16'h00FF, ns);
    op(1, 1, IOP_SPACE_IO, 16'h0009, 16'hFF00, nf);
    `CHK("lat", ns, nf)
    $display("test fast ports done");
    waits <= 4'h5;
    repeat (12)
    begin
      op(0, ns[0], IOP_SPACE_PROG, 16'($random(seed)), 16'($random(seed)), ns);
      op(1, ns[0], IOP_SPACE_IO, {12'h000, 4'($random(seed))}, 16'($random(seed)), nf);
      `CHK("lat", ns, nf)
    end
    $display("test slow ports done");
    fork
      op(1, 1, IOP_SPACE_IO, {12'h000, 4'($random(seed))}, 16'($random(seed)), nf);
      begin
        repeat (4) @(posedge sys_clk);
        clk_en <= 0;
        repeat (6) @(posedge sys_clk);
        clk_en <= 1;
      end
    join
    `CHK("frz", 1'b1, nf > ns)
    $display("test clock enable done");
    repeat (4) @(posedge sys_clk);
    test_done;
  end
endmodule
